// [design/link_cfg_pkg.sv]
/*
  constants, field layouts, reset values and timing counts for the
  radio security, clear-channel and sleep control block.
  assumes a single 25 MHz clock.
*/
package link_cfg_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_PER_SP_UNIT = 10;
  localparam int KEY_W = 128;
  localparam int LEN_W = 8;
  localparam logic [7:0] ENC_MAX_PKT = 8'h5F;
  localparam logic [7:0] IV_BYTES = 8'h10;
  localparam logic [7:0] LONG_ADDR_W = 8'h40;
  localparam logic ENC_RESET = 1'b0;
  localparam logic [2:0] POWER_RESET = 3'h4;
  localparam logic [2:0] POWER_MAX = 3'h4;
  localparam logic [7:0] CCA_RESET = 8'h2C;
  localparam logic [7:0] CCA_MIN = 8'h24;
  localparam logic [7:0] CCA_MAX = 8'h50;
  localparam logic [2:0] SLEEP_RESET = 3'h0;
  localparam logic [15:0] IDLE_RESET = 16'h1388;
  localparam logic [15:0] IDLE_MIN = 16'h0001;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] SP_MAX = 16'h68B0;
  localparam int OPT_NO_POLL = 0;
  localparam int OPT_NO_SAMPLE = 1;
  localparam logic [1:0] MAC_MODE_A = 2'h1;
  localparam logic [1:0] MAC_MODE_B = 2'h2;
  localparam logic [1:0] FRAME_TRANSPARENT = 2'h0;
  localparam logic [1:0] FRAME_API = 2'h1;
  localparam logic [1:0] FRAME_API_ESC = 2'h2;
  localparam logic [2:0] SM_NONE = 3'h0;
  localparam logic [2:0] SM_PIN_HIB = 3'h1;
  localparam logic [2:0] SM_PIN_DOZE = 3'h2;
  localparam logic [2:0] SM_RESERVED = 3'h3;
  localparam logic [2:0] SM_CYCLIC = 3'h4;
  localparam logic [2:0] SM_CYCLIC_PIN = 3'h5;
  localparam logic [2:0] SM_COORD = 3'h6;
  localparam logic [4:0] SEL_ENC = 5'h01;
  localparam logic [4:0] SEL_KEY = 5'h02;
  localparam logic [4:0] SEL_POWER = 5'h04;
  localparam logic [4:0] SEL_CCA = 5'h08;
  localparam logic [4:0] SEL_SLEEP = 5'h10;
  localparam logic [4:0] SEL_IDLE = 5'h11;
  localparam logic [4:0] SEL_SP = 5'h12;
  localparam logic [4:0] SEL_OPTS = 5'h13;
  typedef enum logic [3:0] {
    ST_AWAKE = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_WAKE = 4'b0100,
    ST_PIN_SLEEP = 4'b1000
  } sleep_state_t;
endpackage

// [design/ms_tick_div.sv]
/*
  divider that turns the 25 MHz clock into a one-cycle millisecond enable.
  assumes synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ms_tick_div
  import link_cfg_pkg::*;
#(
  parameter int DIVIDE = CYCLES_PER_MS
)
(
  input wire logic mclk,
  input wire logic reset,
  output logic tick
);
  logic [15:0] count;
  wire at_end = (count == 16'(DIVIDE - 1));
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      count <= at_end ? 16'h0000 : 16'(count + 16'h0001);
      tick <= at_end;
    end
  end
endmodule
`default_nettype wire

// [design/radio_link_ctrl.sv]
/*
  configuration settings, encryption gating, clear-channel gating and
  sleep scheduling for a low-rate radio link layer.
  assumes the host command parser drives cfg_* writes, and the radio
  datapath supplies frame lengths, energy readings and activity strobes.
*/
// Overview of operation
// R1: encryption on/off setting, default off, enables 128-bit block-cipher payload protection.
// R2: with encryption on, packets longer than 95 bytes are refused.
// R3: with encryption on, source field uses the 64-bit long address.
// R4: mac mode 1/2, framed interface, encryption, short address: 64-bit indications only.
// R5: with encryption on, unencrypted received packets are dropped, not forwarded.
// R6: link key write-only; queries and all writes answer OK; only zero or 128-bit valid.
// R7: with encryption on, payload is ciphered and frame check covers ciphertext.
// R8: with encryption on, 16 extra vector bytes are appended per packet.
// R9: transmit power code 0..4, readable and writable, default 4.
// R10: transmission is blocked when measured energy exceeds the clear-channel threshold.
// R11: threshold in minus dBm, accepts 0x24..0x50, default 0x2C.
// R12: sleep mode codes 0..6 decoded, default 0.
// R13: with sleep disabled the device stays idle/receive.
// R14: option bit 0 set skips wake poll; clear polls on each wake; wakes from ST_PIN_SLEEP do not poll.
// R15: option bit 1 set suppresses wake sample; clear samples on wake.
// R16: sleep after idle time in 1 ms steps, 1..0xFFFF, default 0x1388.
// R17: idle timer applies only to cyclic sleep codes 4 and 5.
// R18: host keeps guard time below the idle-before-sleep time.
// R19: cyclic remote sleeps the period in 10 ms units, wakes, checks data.
// R20: coordinator holds indirect messages 2.5 periods; zero period sends directly.
// R21: host programs equal cyclic periods on coordinator and end devices.
// R22: host programs equal idle-before-sleep times on coordinator and end devices.
// R23: frame interface select decodes transparent, framed, framed with escapes.
// R24: reset loads defaults; timers run from a millisecond tick of the clock.
`timescale 1ns/10ps
`default_nettype none
module radio_link_ctrl
  import link_cfg_pkg::*;
#(
  parameter int TICK_DIVIDE = CYCLES_PER_MS
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [4:0] cfg_select,
  input wire logic [KEY_W-1:0] cfg_data,
  input wire logic cfg_key_empty,
  output logic cfg_ok,
  output logic cfg_error,
  output logic cfg_has_value,
  output logic [15:0] cfg_read_data,
  input wire logic [1:0] mac_mode,
  input wire logic [1:0] frame_interface_select,
  input wire logic short_address_set,
  input wire logic tx_request,
  input wire logic [LEN_W-1:0] tx_length,
  input wire logic [7:0] channel_energy,
  output logic tx_go,
  output logic tx_refused_size,
  output logic tx_refused_busy,
  output logic tx_cipher,
  output logic tx_check_on_cipher,
  output logic tx_long_source,
  output logic [7:0] tx_extra_bytes,
  output logic [2:0] transmit_power_level,
  input wire logic rx_valid,
  input wire logic rx_encrypted,
  output logic rx_forward,
  output logic rx_drop,
  output logic rx_long_only,
  output logic [1:0] frame_mode,
  output logic [KEY_W-1:0] link_key,
  input wire logic serial_activity,
  input wire logic radio_activity,
  input wire logic is_coordinator,
  input wire logic pin_sleep_request,
  input wire logic data_pending,
  input wire logic indirect_queued,
  output logic indirect_discard,
  output logic send_direct,
  output logic asleep,
  output logic wake_poll,
  output logic wake_sample
);
  logic encryption_enable;
  logic [7:0] clear_channel_threshold;
  logic [2:0] sleep_mode_select;
  logic [1:0] sleep_options;
  logic [15:0] idle_before_sleep_time;
  logic [15:0] cyclic_sleep_period;
  logic [15:0] idle_ms;
  logic [19:0] sleep_ms;
  logic [20:0] hold_ms;
  sleep_state_t state;
  sleep_state_t next_state;
  logic tick;

  ms_tick_div #(.DIVIDE(TICK_DIVIDE)) u_tick
  (
    .mclk(mclk),
    .reset(reset),
    .tick(tick)
  );

  function automatic logic is_cyclic(input logic [2:0] mode);
    is_cyclic = (mode == SM_CYCLIC) || (mode == SM_CYCLIC_PIN);
  endfunction

  wire wr = cfg_write;
  wire [15:0] wv = cfg_data[15:0];
  wire upper_zero = (cfg_data[KEY_W-1:16] == '0);
  wire ok_enc = upper_zero && (wv <= 16'h0001);
  wire ok_pow = upper_zero && (wv <= 16'(POWER_MAX));
  wire ok_cca = upper_zero && (wv >= 16'(CCA_MIN)) && (wv <= 16'(CCA_MAX));
  wire ok_sm = upper_zero && (wv <= 16'(SM_COORD)) && (wv != 16'(SM_RESERVED));
  wire ok_idle = upper_zero && (wv >= IDLE_MIN);
  wire ok_sp = upper_zero && (wv <= SP_MAX);
  wire ok_opt = upper_zero && (wv <= 16'h0003);
  wire key_ok = !cfg_key_empty;
  wire sel_ok = (cfg_select == SEL_ENC) ? ok_enc :
                (cfg_select == SEL_KEY) ? 1'b1 :
                (cfg_select == SEL_POWER) ? ok_pow :
                (cfg_select == SEL_CCA) ? ok_cca :
                (cfg_select == SEL_SLEEP) ? ok_sm :
                (cfg_select == SEL_IDLE) ? ok_idle :
                (cfg_select == SEL_SP) ? ok_sp :
                (cfg_select == SEL_OPTS) ? ok_opt : 1'b0;
  wire [15:0] read_mux = (cfg_select == SEL_ENC) ? {15'h0000, encryption_enable} :
                         (cfg_select == SEL_POWER) ? {13'h0000, transmit_power_level} :
                         (cfg_select == SEL_CCA) ? {8'h00, clear_channel_threshold} :
                         (cfg_select == SEL_SLEEP) ? {13'h0000, sleep_mode_select} :
                         (cfg_select == SEL_IDLE) ? idle_before_sleep_time :
                         (cfg_select == SEL_SP) ? cyclic_sleep_period :
                         (cfg_select == SEL_OPTS) ? {14'h0000, sleep_options} : 16'h0000;
  wire sel_known = sel_ok || (cfg_select == SEL_KEY) || (read_mux != 16'h0000) ||
                   (cfg_select inside {SEL_ENC, SEL_POWER, SEL_CCA, SEL_SLEEP,
                                       SEL_IDLE, SEL_SP, SEL_OPTS});

  // configuration store with range checks
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      encryption_enable <= ENC_RESET; // R1 R24
      link_key <= '0;
      transmit_power_level <= POWER_RESET; // R9 R24
      clear_channel_threshold <= CCA_RESET; // R11 R24
      sleep_mode_select <= SLEEP_RESET; // R12 R24
      sleep_options <= 2'h0;
      idle_before_sleep_time <= IDLE_RESET; // R16 R24
      cyclic_sleep_period <= SP_RESET;
    end
    else if (wr && sel_ok)
    begin
      unique case (cfg_select)
        SEL_ENC: encryption_enable <= wv[0]; // R1
        SEL_KEY: if (key_ok) link_key <= cfg_data; // R6
        SEL_POWER: transmit_power_level <= wv[2:0]; // R9
        SEL_CCA: clear_channel_threshold <= wv[7:0]; // R11
        SEL_SLEEP: sleep_mode_select <= wv[2:0]; // R12
        SEL_IDLE: idle_before_sleep_time <= wv; // R16
        SEL_SP: cyclic_sleep_period <= wv; // R19
        default: sleep_options <= wv[1:0];
      endcase
    end
  end

  // command answers: key queries and writes always OK with no value
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cfg_ok <= 1'b0;
      cfg_error <= 1'b0;
      cfg_has_value <= 1'b0;
      cfg_read_data <= 16'h0000;
    end
    else
    begin
      cfg_ok <= (cfg_write && (sel_ok || cfg_select == SEL_KEY)) ||
                (cfg_read && sel_known); // R6
      cfg_error <= (cfg_write && !sel_ok && cfg_select != SEL_KEY) ||
                   (cfg_read && !sel_known);
      cfg_has_value <= cfg_read && sel_known && (cfg_select != SEL_KEY); // R6
      cfg_read_data <= (cfg_read && cfg_select != SEL_KEY) ? read_mux : 16'h0000; // R6
    end
  end

  wire too_long = encryption_enable && (tx_length > ENC_MAX_PKT);
  wire busy = channel_energy < clear_channel_threshold;
  wire framed = (frame_interface_select == FRAME_API) ||
                (frame_interface_select == FRAME_API_ESC);
  wire mac_ab = (mac_mode == MAC_MODE_A) || (mac_mode == MAC_MODE_B);

  // transmit gating and per-frame security controls
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_go <= 1'b0;
      tx_refused_size <= 1'b0;
      tx_refused_busy <= 1'b0;
      tx_cipher <= 1'b0;
      tx_check_on_cipher <= 1'b0;
      tx_long_source <= 1'b0;
      tx_extra_bytes <= 8'h00;
      rx_forward <= 1'b0;
      rx_drop <= 1'b0;
      rx_long_only <= 1'b0;
      frame_mode <= FRAME_TRANSPARENT;
    end
    else
    begin
      tx_refused_size <= tx_request && too_long; // R2
      tx_refused_busy <= tx_request && !too_long && busy; // R10
      tx_go <= tx_request && !too_long && !busy && !asleep; // R10
      tx_cipher <= encryption_enable; // R7
      tx_check_on_cipher <= encryption_enable; // R7
      tx_long_source <= encryption_enable; // R3
      tx_extra_bytes <= encryption_enable ? IV_BYTES : 8'h00; // R8
      rx_drop <= rx_valid && encryption_enable && !rx_encrypted; // R5
      rx_forward <= rx_valid && !(encryption_enable && !rx_encrypted); // R5
      rx_long_only <= mac_ab && framed && encryption_enable && short_address_set; // R4
      frame_mode <= frame_interface_select; // R23
    end
  end

  wire traffic = serial_activity || radio_activity;
  wire cyclic = is_cyclic(sleep_mode_select) && !is_coordinator; // R17
  wire pin_mode = (sleep_mode_select == SM_PIN_HIB) || (sleep_mode_select == SM_PIN_DOZE);
  wire idle_done = tick && (idle_ms >= idle_before_sleep_time - 16'h0001);
  wire [19:0] sp_ms = 20'(cyclic_sleep_period) * 20'(MS_PER_SP_UNIT);
  wire [20:0] hold_limit = 21'({sp_ms, 1'b0}) + 21'(sp_ms >> 1); // R20
  wire period_done = tick && (sleep_ms + 20'h00001 >= sp_ms);
  wire pin_wake = (sleep_mode_select == SM_CYCLIC_PIN) && !pin_sleep_request;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_AWAKE:
        if (sleep_mode_select == SM_NONE) next_state = ST_AWAKE; // R13
        else if (pin_mode && pin_sleep_request) next_state = ST_PIN_SLEEP;
        else if (cyclic && !traffic && idle_done) next_state = ST_SLEEP; // R16 R17
      ST_SLEEP:
        if (!cyclic || period_done || pin_wake) next_state = ST_WAKE; // R19
      ST_WAKE:
        if (data_pending || traffic || !cyclic) next_state = ST_AWAKE; // R19
        else next_state = ST_SLEEP; // R19
      ST_PIN_SLEEP:
        if (!pin_sleep_request || !pin_mode) next_state = ST_AWAKE;
      default: next_state = ST_AWAKE;
    endcase
  end

  // sleep scheduler and timers on the millisecond tick
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= ST_AWAKE;
      idle_ms <= 16'h0000;
      sleep_ms <= 20'h00000;
      asleep <= 1'b0;
      wake_poll <= 1'b0;
      wake_sample <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (traffic || state != ST_AWAKE) idle_ms <= 16'h0000; // R16
      else if (tick) idle_ms <= 16'(idle_ms + 16'h0001); // R24
      if (state != ST_SLEEP) sleep_ms <= 20'h00000;
      else if (tick) sleep_ms <= 20'(sleep_ms + 20'h00001); // R19
      asleep <= (next_state == ST_SLEEP) || (next_state == ST_PIN_SLEEP);
      wake_poll <= (next_state == ST_WAKE) && !sleep_options[OPT_NO_POLL]; // R14
      wake_sample <= ((next_state == ST_WAKE) ||
                      (state == ST_PIN_SLEEP && next_state == ST_AWAKE))
                     && !sleep_options[OPT_NO_SAMPLE]; // R15
    end
  end

  // coordinator indirect hold timer
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hold_ms <= 21'h000000;
      indirect_discard <= 1'b0;
      send_direct <= 1'b1;
    end
    else
    begin
      send_direct <= (cyclic_sleep_period == 16'h0000); // R20
      indirect_discard <= 1'b0;
      if (!indirect_queued || !is_coordinator || cyclic_sleep_period == 16'h0000)
        hold_ms <= 21'h000000;
      else if (tick)
      begin
        if (hold_ms + 21'h000001 >= hold_limit)
        begin
          indirect_discard <= 1'b1; // R20
          hold_ms <= 21'h000000;
        end
        else
          hold_ms <= 21'(hold_ms + 21'h000001);
      end
    end
  end
endmodule
`default_nettype wire

// [verification/radio_link_ctrl_monitor.sv]
/*
  concurrent checks on the ports of radio_link_ctrl.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module radio_link_ctrl_monitor
  import link_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [4:0] cfg_select,
  input wire logic [KEY_W-1:0] cfg_data,
  input wire logic cfg_ok,
  input wire logic cfg_error,
  input wire logic cfg_has_value,
  input wire logic tx_request,
  input wire logic [LEN_W-1:0] tx_length,
  input wire logic [7:0] channel_energy,
  input wire logic tx_go,
  input wire logic tx_refused_size,
  input wire logic tx_refused_busy,
  input wire logic [7:0] tx_extra_bytes,
  input wire logic rx_valid,
  input wire logic rx_encrypted,
  input wire logic rx_forward,
  input wire logic rx_drop,
  input wire logic [2:0] transmit_power_level,
  input wire logic asleep
);
  logic wr_d;
  logic enc_on;
  // encryption seen as on once the extra-byte output settled
  always_ff @(posedge mclk)
  begin
    wr_d <= cfg_write;
  end
  assign enc_on = (tx_extra_bytes == IV_BYTES) && !wr_d;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_ok;
    ##1 (cfg_ok && !cfg_error);
  endsequence
  sequence s_bad;
    ##1 (cfg_error && !cfg_ok);
  endsequence
  property p_key_wr; cfg_write && cfg_select == SEL_KEY |-> s_ok; endproperty
  a_key_wr: assert property (p_key_wr) else $error("key write not ok");
  property p_key_rd; cfg_read && cfg_select == SEL_KEY |-> s_ok ##0 !cfg_has_value; endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read gave value");
  property p_pwr_wr; cfg_write && cfg_select == SEL_POWER && cfg_data[15:0] <= 16'h0004
    |=> cfg_ok && transmit_power_level == $past(cfg_data[2:0]); endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("power write lost");
  property p_pwr_max; transmit_power_level <= POWER_MAX; endproperty
  a_pwr_max: assert property (p_pwr_max) else $error("power code above 4");
  property p_cca_bad; cfg_write && cfg_select == SEL_CCA
    && (cfg_data[15:0] < 16'h0024 || cfg_data[15:0] > 16'h0050) |-> s_bad; endproperty
  a_cca_bad: assert property (p_cca_bad) else $error("threshold range not refused");
  property p_enc_bad; cfg_write && cfg_select == SEL_ENC && cfg_data[15:0] > 16'h0001 |-> s_bad;
  endproperty
  a_enc_bad: assert property (p_enc_bad) else $error("cipher switch range");
  property p_size; tx_request && enc_on && tx_length > ENC_MAX_PKT |=> tx_refused_size && !tx_go;
  endproperty
  a_size: assert property (p_size) else $error("long packet sent");
  property p_busy; tx_request && channel_energy < CCA_MIN && tx_length <= ENC_MAX_PKT
    |=> tx_refused_busy && !tx_go;
  endproperty
  a_busy: assert property (p_busy) else $error("busy channel sent");
  property p_drop; rx_valid && enc_on && !rx_encrypted |=> rx_drop && !rx_forward; endproperty
  a_drop: assert property (p_drop) else $error("plain frame forwarded");
  property p_reset; $fell(reset) |-> transmit_power_level == POWER_RESET && !asleep; endproperty
  a_reset: assert property (p_reset) else $error("reset defaults");
endmodule
bind radio_link_ctrl radio_link_ctrl_monitor u_mon (.mclk(mclk), .reset(reset),
  .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_select(cfg_select), .cfg_data(cfg_data),
  .cfg_ok(cfg_ok), .cfg_error(cfg_error), .cfg_has_value(cfg_has_value),
  .tx_request(tx_request), .tx_length(tx_length), .channel_energy(channel_energy),
  .tx_go(tx_go), .tx_refused_size(tx_refused_size), .tx_refused_busy(tx_refused_busy),
  .tx_extra_bytes(tx_extra_bytes), .rx_valid(rx_valid), .rx_encrypted(rx_encrypted),
  .rx_forward(rx_forward), .rx_drop(rx_drop),
  .transmit_power_level(transmit_power_level), .asleep(asleep));
`default_nettype wire

// [verification/radio_peer_model.sv]
/*
  remote radio node: hands one received frame to the block per request.
  assumes send is raised for one cycle just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module radio_peer_model
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic send,
  input wire logic enc,
  output logic rx_valid,
  output logic rx_encrypted,
  output logic radio_activity
);
  // the cipher flag means nothing outside a frame, so it toggles there
  always_ff @(posedge mclk)
  begin
    rx_valid <= !reset && send;
    rx_encrypted <= reset ? 1'b0 : (send ? enc : ~rx_encrypted);
  end
  assign radio_activity = rx_valid;
endmodule
`default_nettype wire

// [verification/tb_radio_link_ctrl.sv]
/*
  self-checking bench for radio_link_ctrl with a remote node model.
  assumes a 25 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_radio_link_ctrl
  import link_cfg_pkg::*;
;
  logic mclk, reset, cfg_write, cfg_read, cfg_key_empty, short_address_set, tx_request;
  logic serial_activity, is_coordinator, pin_sleep_request, data_pending, indirect_queued;
  logic peer_send, peer_enc, cfg_ok, cfg_error, cfg_has_value, tx_go, tx_refused_size;
  logic tx_refused_busy, tx_cipher, tx_check_on_cipher, tx_long_source, rx_valid;
  logic rx_encrypted, rx_forward, rx_drop, rx_long_only, indirect_discard, send_direct;
  logic asleep, wake_poll, wake_sample, radio_activity;
  logic [4:0] cfg_select;
  logic [KEY_W-1:0] cfg_data, link_key;
  logic [1:0] mac_mode, frame_interface_select, frame_mode;
  logic [7:0] tx_length, channel_energy, tx_extra_bytes;
  logic [15:0] cfg_read_data;
  logic [2:0] transmit_power_level;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  radio_link_ctrl #(.TICK_DIVIDE(4)) DUT (.mclk(mclk), .reset(reset), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_select(cfg_select), .cfg_data(cfg_data),
    .cfg_key_empty(cfg_key_empty), .cfg_ok(cfg_ok), .cfg_error(cfg_error),
    .cfg_has_value(cfg_has_value), .cfg_read_data(cfg_read_data), .mac_mode(mac_mode),
    .frame_interface_select(frame_interface_select), .short_address_set(short_address_set),
    .tx_request(tx_request), .tx_length(tx_length), .channel_energy(channel_energy),
    .tx_go(tx_go), .tx_refused_size(tx_refused_size), .tx_refused_busy(tx_refused_busy),
    .tx_cipher(tx_cipher), .tx_check_on_cipher(tx_check_on_cipher),
    .tx_long_source(tx_long_source), .tx_extra_bytes(tx_extra_bytes),
    .transmit_power_level(transmit_power_level), .rx_valid(rx_valid),
    .rx_encrypted(rx_encrypted), .rx_forward(rx_forward), .rx_drop(rx_drop),
    .rx_long_only(rx_long_only), .frame_mode(frame_mode), .link_key(link_key),
    .serial_activity(serial_activity), .radio_activity(radio_activity),
    .is_coordinator(is_coordinator), .pin_sleep_request(pin_sleep_request),
    .data_pending(data_pending), .indirect_queued(indirect_queued),
    .indirect_discard(indirect_discard), .send_direct(send_direct), .asleep(asleep),
    .wake_poll(wake_poll), .wake_sample(wake_sample));
  radio_peer_model PEER (.mclk(mclk), .reset(reset), .send(peer_send), .enc(peer_enc),
    .rx_valid(rx_valid), .rx_encrypted(rx_encrypted), .radio_activity(radio_activity));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [127:0] g, input logic [127:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task cmd(input logic w, input logic [4:0] s, input logic [KEY_W-1:0] d, input logic e);
    step(1);
    cfg_write = w;
    cfg_read = !w;
    cfg_select = s;
    cfg_data = d;
    cfg_key_empty = e;
    step(1);
    cfg_write = 1'b0;
    cfg_read = 1'b0;
  endtask
  task wr(input logic [4:0] s, input logic [15:0] d, input logic good);
    cmd(1'b1, s, {112'h0, d}, 1'b0);
    chk({cfg_ok, cfg_error}, {good, !good});
  endtask
  task rdck(input logic [4:0] s, input logic [15:0] v);
    cmd(1'b0, s, '0, 1'b0);
    chk({cfg_ok, cfg_has_value, cfg_read_data}, {2'b11, v});
  endtask
  task tx(input logic [7:0] len, input logic [7:0] en, input logic [2:0] exp);
    step(1);
    tx_request = 1'b1;
    tx_length = len;
    channel_energy = en;
    step(1);
    tx_request = 1'b0;
    chk({tx_go, tx_refused_size, tx_refused_busy}, exp);
  endtask
  task rx(input logic enc, input logic [1:0] exp);
    step(1);
    peer_send = 1'b1;
    peer_enc = enc;
    step(1);
    peer_send = 1'b0;
    step(1);
    chk({rx_forward, rx_drop}, exp);
  endtask
  task t_defaults();
    chk({transmit_power_level, send_direct, asleep, frame_mode}, 7'h48);
    chk(link_key, 128'h0);
    rdck(SEL_CCA, 16'h002C);
    rdck(SEL_IDLE, 16'h1388);
    rdck(SEL_SLEEP, 16'h0000);
    rdck(SEL_ENC, 16'h0000);
  endtask
  task t_ranges();
    for (int p = 0; p < 6; p++)
    begin
      wr(SEL_POWER, 16'(p), p < 5);
      rdck(SEL_POWER, (p < 5) ? 16'(p) : 16'h0004);
    end
    for (int m = 0; m < 8; m++)
      wr(SEL_SLEEP, 16'(m), m != 3 && m != 7);
    rdck(SEL_SLEEP, 16'h0006);
    wr(SEL_CCA, 16'h0023, 1'b0);
    wr(SEL_CCA, 16'h0051, 1'b0);
    wr(SEL_CCA, 16'h0050, 1'b1);
    wr(SEL_CCA, 16'h0024, 1'b1);
    wr(SEL_CCA, 16'h002C, 1'b1);
    wr(SEL_ENC, 16'h0002, 1'b0);
    wr(SEL_IDLE, 16'h0000, 1'b0);
    wr(SEL_IDLE, 16'hFFFF, 1'b1);
    wr(SEL_SP, 16'h68B1, 1'b0);
    wr(SEL_SP, 16'h68B0, 1'b1);
    wr(SEL_OPTS, 16'h0004, 1'b0);
    wr(5'h1F, 16'h0000, 1'b0);
  endtask
  task t_key();
    cmd(1'b0, SEL_KEY, '0, 1'b0);
    chk({cfg_ok, cfg_has_value}, 2'b10);
    cmd(1'b1, SEL_KEY, {4{32'hA5C3F00F}}, 1'b0);
    chk({cfg_ok, link_key}, {1'b1, {4{32'hA5C3F00F}}});
    cmd(1'b1, SEL_KEY, '0, 1'b1);
    chk({cfg_ok, link_key}, {1'b1, {4{32'hA5C3F00F}}});
    cmd(1'b1, SEL_KEY, '0, 1'b0);
    chk({cfg_ok, link_key}, {1'b1, 128'h0});
  endtask
  task t_cipher();
    wr(SEL_ENC, 16'h0001, 1'b1);
    step(1);
    chk({tx_cipher, tx_check_on_cipher, tx_long_source, tx_extra_bytes}, 11'h710);
    tx(8'd95, 8'h50, 3'b100);
    tx(8'd96, 8'h50, 3'b010);
    rx(1'b0, 2'b01);
    rx(1'b1, 2'b10);
    mac_mode = MAC_MODE_B;
    frame_interface_select = FRAME_API;
    short_address_set = 1'b1;
    step(2);
    chk(rx_long_only, 1'b1);
    mac_mode = 2'h0;
    for (int f = 0; f < 3; f++)
    begin
      frame_interface_select = 2'(f);
      step(2);
      chk({rx_long_only, frame_mode}, 3'(f));
    end
    wr(SEL_ENC, 16'h0000, 1'b1);
    step(1);
    chk({tx_cipher, tx_extra_bytes}, 9'h000);
    tx(8'd96, 8'h50, 3'b100);
    rx(1'b0, 2'b10);
  endtask
  task t_clear_channel();
    tx(8'd20, 8'h2B, 3'b001);
    tx(8'd20, 8'h2C, 3'b100);
    tx(8'd20, 8'h20, 3'b001);
  endtask
  task t_sleep();
    int i;
    wr(SEL_IDLE, 16'h0003, 1'b1);
    wr(SEL_SP, 16'h0001, 1'b1);
    wr(SEL_OPTS, 16'h0000, 1'b1);
    wr(SEL_SLEEP, 16'h0000, 1'b1);
    step(40);
    chk(asleep, 1'b0);
    wr(SEL_SLEEP, 16'h0004, 1'b1);
    for (i = 0; i < 60 && asleep !== 1'b1; i++) step(1);
    chk(asleep, 1'b1);
    for (i = 0; i < 120 && wake_poll !== 1'b1; i++) step(1);
    chk({wake_poll, wake_sample}, 2'b11);
    wr(SEL_OPTS, 16'h0003, 1'b1);
    for (i = 0; i < 120 && asleep !== 1'b0; i++) step(1);
    chk({i < 120, wake_poll, wake_sample}, 3'b100);
    is_coordinator = 1'b1;
    step(2);
    chk(send_direct, 1'b0);
    indirect_queued = 1'b1;
    for (i = 0; i < 150 && indirect_discard !== 1'b1; i++) step(1);
    chk({indirect_discard, i > 90}, 2'b11);
    indirect_queued = 1'b0;
    wr(SEL_SP, 16'h0000, 1'b1);
    step(2);
    chk(send_direct, 1'b1);
  endtask
  initial
  begin
    {reset, cfg_write, cfg_read, cfg_key_empty, short_address_set, tx_request} = 6'h20;
    {serial_activity, is_coordinator, pin_sleep_request, data_pending} = 4'h0;
    {indirect_queued, peer_send, peer_enc, mac_mode, frame_interface_select} = 7'h00;
    {cfg_select, cfg_data, tx_length, channel_energy} = '0;
    repeat (6) @(posedge mclk);
    #2;
    reset = 1'b0;
    t_defaults();
    t_ranges();
    t_key();
    t_cipher();
    t_clear_channel();
    t_sleep();
    summarize();
  end
endmodule
`default_nettype wire
